// ==== dv/serial_in_latched_sink_driver_tb_top.sv ====
// Purpose: bench comparing the sink driver with a bench model
// Assumes: sls_host moves the pins on falling edges
// Notes: outputs are compared four clocks after each shift or latch pulse rises, as that pulse falls
`timescale 1ns/1ps
`default_nettype none
module serial_in_latched_sink_driver_tb_top;
  logic      ref_clk = 1'b0, rst = 1'b1, c = 1'b1, e = 1'b0;
  wire logic data_in_line, shift_clock, latch_clock, shift_clear_n, out_enable_n, cascade_out;
  wire logic [7:0] sink_out;
  int        sr = 0, st = 0, errors = 0, n_compared = 0;
  // 50 ns period
  always #25 ref_clk = ~ref_clk;
  sls_host i_host (.ref_clk, .data_in_line, .shift_clock, .latch_clock, .shift_clear_n,
    .out_enable_n);
  sls_driver i_dut (.ref_clk, .rst, .data_in_line, .shift_clock, .latch_clock,
    .shift_clear_n, .out_enable_n, .cascade_out, .sink_out);
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    errors += int'(seen !== exp);
    if (seen !== exp) $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
  endtask
  // cascade is stage 7; sinks show storage only while clear is high and enabled
  task automatic look();
    check({cascade_out, sink_out}, {sr[7], st[7:0] & {8{c & ~e}}});
  endtask
  // farthest bit first, then one latch pulse; shifts under a clear are lost
  task automatic send(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      i_host.step(v[i], 1, c, e);
      sr = c ? ((sr << 1) | v[i]) & 8'hff : 0;
      look();
    end
    i_host.step(1'b0, 2, c, e);
    st = sr;
    look();
  endtask
  // random bytes, one latched while disabled, then a clear that must spare storage
  initial begin
    void'($urandom(32'h669d92f2));
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    for (int k = 0; k < 6; k++) begin
      e = (k == 3);
      send(8'($urandom));
    end
    c = 1'b0;
    sr = 0;
    i_host.step(1'b1, 1, c, e);
    look();
    c = 1'b1;
    send(8'($urandom));
    finish_test(0);
  end
  // the run needs about 530 clocks
  initial begin
    repeat (5000) @(posedge ref_clk);
    finish_test(1);
  end
  task automatic finish_test(input int hang);
    errors += hang;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
endmodule // serial_in_latched_sink_driver_tb_top
`default_nettype wire

// ==== dv/sls_host.sv ====
// Purpose: host controller model driving the sink driver pins
// Assumes: pins move on falling ref_clk edges only
// Notes: each level holds 4 clocks, above the 3 the driver needs
`timescale 1ns/1ps
`default_nettype none
module sls_host (
  // clock and driver pins
  input  wire logic ref_clk,
  output logic      data_in_line = 1'b0,
  output logic      shift_clock = 1'b0,
  output logic      latch_clock = 1'b0,
  output logic      shift_clear_n = 1'b1,
  output logic      out_enable_n = 1'b0
);
  // set levels, then a shift (m 1) or latch (m 2) pulse 4 clocks high
  task automatic step(input logic b, input int m, input logic c, input logic e);
    data_in_line = b;
    shift_clear_n = c;
    out_enable_n = e;
    repeat (4) @(negedge ref_clk);
    shift_clock = (m == 1);
    latch_clock = (m == 2);
    repeat (4) @(negedge ref_clk);
    shift_clock = 1'b0;
    latch_clock = 1'b0;
  endtask
endmodule // sls_host
`default_nettype wire

// ==== include/sls_pkg.sv ====
// Purpose: shared constants for the serial-in latched sink driver
// Assumes: one 20 MHz system clock; all device pins sampled through two flip-flops
// Notes:   widths and reset values only; no registers reachable by software
package sls_pkg;
  localparam int          SLS_WIDTH      = 8;
  localparam int          SLS_SYNC_DEPTH = 2;
  localparam logic [7:0]  SLS_SHIFT_RST  = 8'h00;
  localparam logic [7:0]  SLS_STORE_RST  = 8'h00;
  localparam int          SLS_TOP_STAGE  = SLS_WIDTH - 1;
endpackage : sls_pkg

// ==== src/sls_driver.sv ====
// Purpose: serial-in shift register, storage latch and gated sink outputs
// Assumes: host pins are slow against ref_clk (edges apart by several clocks)
// Notes:   edges of shift_clock and latch_clock are found after synchronising
`timescale 1ns/1ps
`default_nettype none
module sls_driver #(
  parameter int WIDTH = sls_pkg::SLS_WIDTH
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // host pins
  input  wire logic             data_in_line,
  input  wire logic             shift_clock,
  input  wire logic             latch_clock,
  input  wire logic             shift_clear_n,
  input  wire logic             out_enable_n,
  // chain and sink outputs
  output logic                  cascade_out,
  output logic      [WIDTH-1:0] sink_out
);
  import sls_pkg::*;

  // synchronised pins: {data, shift clk, latch clk, clear_n, enable_n}
  logic [4:0] pin_sync;
  logic       data_s;
  logic       shift_s;
  logic       latch_s;
  logic       clear_n_s;
  logic       oe_n_s;

  sls_sync #(.WIDTH(5)) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin_in   ({data_in_line, shift_clock, latch_clock, shift_clear_n, out_enable_n}),
    .pin_rst  (5'h00),
    .pin_sync (pin_sync)
  );
  assign {data_s, shift_s, latch_s, clear_n_s, oe_n_s} = pin_sync;

  // edge history of the synchronised clocks
  logic             shift_d;
  logic             latch_d;
  logic             shift_rise;
  logic             latch_rise;
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] store_reg;
  logic [WIDTH-1:0] next_shift_reg;
  logic [WIDTH-1:0] next_store_reg;
  logic [WIDTH-1:0] next_sink;
  logic             next_cascade;

  assign shift_rise = shift_s & ~shift_d;
  assign latch_rise = latch_s & ~latch_d;

  // shift register and storage register next values
  always_comb begin
    next_shift_reg = shift_reg;
    next_store_reg = store_reg;
    if (!clear_n_s) begin
      next_shift_reg = SLS_SHIFT_RST[WIDTH-1:0];
    end else if (shift_rise) begin
      next_shift_reg = {shift_reg[WIDTH-2:0], data_s};
    end
    // latch copies the pre-shift stages when both edges coincide, as a real flop pair would
    if (latch_rise) begin
      next_store_reg = shift_reg;
    end
  end

  // buffer pass condition: enable low and clear high, both as synchronised levels
  logic             buffer_open;
  logic [WIDTH-1:0] gated_store;
  assign buffer_open = !oe_n_s && clear_n_s;

  // one gate per sink bit; storage bit n drives sink n and nothing else
  for (genvar g = 0; g < WIDTH; g++) begin : g_sink
    assign gated_store[g] = next_store_reg[g] & buffer_open;
  end

  // output buffer and chain output next values
  // the gate uses next_store_reg so a latch edge reaches the sinks in the same clock
  always_comb begin
    next_sink    = gated_store;
    next_cascade = next_shift_reg[WIDTH-1];
  end

  // registers only; outputs come from flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_d     <= 1'b0;
      latch_d     <= 1'b0;
      shift_reg   <= SLS_SHIFT_RST[WIDTH-1:0];
      store_reg   <= SLS_STORE_RST[WIDTH-1:0];
      sink_out    <= '0;
      cascade_out <= 1'b0;
    end else begin
      shift_d     <= shift_s;
      latch_d     <= latch_s;
      shift_reg   <= next_shift_reg;
      store_reg   <= next_store_reg;
      sink_out    <= next_sink;
      cascade_out <= next_cascade;
    end
  end

  // checks
  sequence shift_edge_s;
    shift_rise && clear_n_s;
  endsequence

  shift_advance_a : assert property (@(posedge ref_clk) disable iff (rst)
    shift_edge_s |=> shift_reg == {$past(shift_reg[WIDTH-2:0]), $past(data_s)})
    else $error("shift register did not advance");
  latch_copy_a : assert property (@(posedge ref_clk) disable iff (rst)
    latch_rise |=> store_reg == $past(shift_reg))
    else $error("storage did not take shift stages");
  clear_zero_a : assert property (@(posedge ref_clk) disable iff (rst)
    !clear_n_s |=> shift_reg == '0)
    else $error("clear did not zero shift register");
  clear_keep_a : assert property (@(posedge ref_clk) disable iff (rst)
    (!clear_n_s && !latch_rise) |=> $stable(store_reg))
    else $error("clear disturbed storage register");
  clear_gate_a : assert property (@(posedge ref_clk) disable iff (rst)
    !clear_n_s |=> sink_out == '0)
    else $error("sinks active while clear low");
  enable_off_a : assert property (@(posedge ref_clk) disable iff (rst)
    oe_n_s |=> sink_out == '0)
    else $error("sinks active while disabled");
  enable_follow_a : assert property (@(posedge ref_clk) disable iff (rst)
    (!oe_n_s && clear_n_s) |=> sink_out == store_reg)
    else $error("sinks do not follow storage");
  cascade_top_a : assert property (@(posedge ref_clk) disable iff (rst)
    cascade_out == shift_reg[WIDTH-1])
    else $error("cascade output not top stage");

  // further steps of a shift and a latch, built from named sequences
  sequence latch_edge_s;
    latch_rise;
  endsequence

  sequence shift_idle_s;
    clear_n_s && !shift_rise;
  endsequence

  sequence clear_edge_s;
    !clear_n_s && shift_rise;
  endsequence

  sequence both_edges_s;
    shift_rise && latch_rise && clear_n_s;
  endsequence

  // a shift moves the old stage six onto the chain output
  cascade_shift_a : assert property (@(posedge ref_clk) disable iff (rst)
    shift_edge_s |=> cascade_out == $past(shift_reg[WIDTH-2]))
    else $error("cascade output did not take stage six");

  // the serial bit lands in stage zero
  stage_zero_a : assert property (@(posedge ref_clk) disable iff (rst)
    shift_edge_s |=> shift_reg[0] == $past(data_s))
    else $error("serial bit not in stage zero");

  // without an edge the stages must not move
  shift_hold_a : assert property (@(posedge ref_clk) disable iff (rst)
    shift_idle_s |=> shift_reg == $past(shift_reg))
    else $error("shift register moved without an edge");

  // one pin edge gives exactly one shift
  shift_once_a : assert property (@(posedge ref_clk) disable iff (rst)
    shift_edge_s |=> !shift_rise)
    else $error("one shift edge seen twice");

  // storage only changes on a latch edge
  store_hold_a : assert property (@(posedge ref_clk) disable iff (rst)
    !latch_rise |=> $stable(store_reg))
    else $error("storage changed without latch edge");

  // one latch edge gives exactly one copy
  latch_once_a : assert property (@(posedge ref_clk) disable iff (rst)
    latch_edge_s |=> !latch_rise)
    else $error("one latch edge seen twice");

  // clear wins over a shift edge in the same clock
  clear_wins_a : assert property (@(posedge ref_clk) disable iff (rst)
    clear_edge_s |=> shift_reg == '0)
    else $error("shift edge beat the clear");

  // coincident edges: storage takes the stages as they were before the shift
  both_edges_a : assert property (@(posedge ref_clk) disable iff (rst)
    both_edges_s |=> store_reg == $past(shift_reg))
    else $error("coincident edges took shifted stages");

  // any active sink implies the buffer was open one clock before
  sink_gate_a : assert property (@(posedge ref_clk) disable iff (rst)
    (sink_out != '0) |-> ($past(clear_n_s) && !$past(oe_n_s)))
    else $error("sink active while buffer closed");

  // per sink: an active sink always has its storage bit set
  for (genvar g = 0; g < WIDTH; g++) begin : g_sink_chk
    sink_bit_a : assert property (@(posedge ref_clk) disable iff (rst)
      sink_out[g] |-> store_reg[g])
      else $error("sink on with storage bit clear");
  end
endmodule // sls_driver
`default_nettype wire

// ==== src/sls_sync.sv ====
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to ref_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module sls_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] pin_rst,
  output logic      [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_pin_sync;

  // pure pass-through of the stages
  always_comb begin
    next_meta     = pin_in;
    next_pin_sync = meta;
  end

  // reset loads zero into both stages; the pin_rst tie from the parent is unused
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta     <= '0;
      pin_sync <= '0;
    end else begin
      meta     <= next_meta;
      pin_sync <= next_pin_sync;
    end
  end

  logic unused_rst_val;
  assign unused_rst_val = ^pin_rst;
endmodule // sls_sync
`default_nettype wire
